// ===== verilog/lsr_regs.svh
// Register offsets, field positions and reset values of the lock status bank
`ifndef LSR_REGS_SVH
`define LSR_REGS_SVH
`define LSR_ADDR_PIN2_SEL 9'h16e
`define LSR_ADDR_FIX_A 9'h171
`define LSR_ADDR_FIX_B 9'h172
`define LSR_ADDR_PWR 9'h173
`define LSR_ADDR_OPT_A 9'h17c
`define LSR_ADDR_OPT_B 9'h17d
`define LSR_ADDR_LOCK1 9'h182
`define LSR_ADDR_LOCK2 9'h183
`define LSR_ADDR_IRQ_STAT 9'h190
`define LSR_ADDR_IRQ_MASK 9'h191
`define LSR_ADDR_LCNT1 9'h192
`define LSR_ADDR_LCNT2 9'h193
`define LSR_RST_PIN2_SEL 8'h16
`define LSR_RST_FIX_A 8'h0a
`define LSR_RST_FIX_B 8'h00
`define LSR_RST_BYTE 8'h00
`define LSR_RST_LCNT 8'h10
`define LSR_BIT_PRE_OFF 6
`define LSR_BIT_LOOP_OFF 5
`define LSR_BIT_LOST 2
`define LSR_BIT_LEVEL 1
`define LSR_BIT_CLEAR 0
`endif

// ===== verilog/lsr_pkg.sv
// Types shared by the lock status bank
package lsr_pkg;
    typedef enum logic [4:0] {
        LSR_SRC_LOW = 5'h00, LSR_SRC_LOCK1 = 5'h01, LSR_SRC_LOCK2 = 5'h02,
        LSR_SRC_BOTH = 5'h03, LSR_SRC_HOLD = 5'h04, LSR_SRC_DACLK = 5'h05,
        LSR_SRC_RDBK = 5'h07, LSR_SRC_RAIL = 5'h08, LSR_SRC_DLOW = 5'h09,
        LSR_SRC_DHIGH = 5'h0a, LSR_SRC_FB1 = 5'h0b, LSR_SRC_FB1H = 5'h0c,
        LSR_SRC_FB2 = 5'h0d, LSR_SRC_FB2H = 5'h0e, LSR_SRC_RF1 = 5'h0f,
        LSR_SRC_RF1H = 5'h10, LSR_SRC_RF2 = 5'h11, LSR_SRC_RF2H = 5'h12
    } lsr_src_t;
    typedef enum logic [2:0] {
        LSR_DRV_PP = 3'h3, LSR_DRV_PPINV = 3'h4, LSR_DRV_OD = 3'h6
    } lsr_drv_t;
    typedef struct packed {
        logic [4:0] source;
        logic [2:0] drive;
    } lsr_pin_sel_t;
    // Analog-side indications: holdover, dac locked, rail, low, high
    typedef struct packed {
        logic holdover;
        logic dac_locked;
        logic dac_rail;
        logic dac_low;
        logic dac_high;
    } lsr_misc_t;
endpackage

// ===== verilog/lsr_bank.sv
// Lock status register bank with lock detectors and status pin driver
// What this block does
// - Pin two follows five-bit source selector
// - Drive field picks push-pull, inverted, open-drain
// - Prescaler-off bit powers down second prescaler
// - Loop-off bit powers down whole second loop
// - First lost flag sets on lock fall
// - First level bit reads live lock
// - First clear bit holds lost flag low
// - Second lost flag sets on lock fall
// - Second level bit reads live lock
// - Second clear bit holds lost flag low
// - Lock after count in window, else restart
`timescale 1ns/100ps
`default_nettype none
`include "lsr_regs.svh"

module lsr_lock_det
    import lsr_pkg::*;
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    // Loop side
    input wire logic i_off,
    input wire logic i_pd_pin,
    input wire logic i_win_pin,
    // Control and status
    input wire logic [7:0] i_lock_cnt,
    input wire logic i_clear,
    output logic o_level,
    output logic o_lost,
    output logic o_event
);
    logic [1:0] pd_sync_reg, pd_sync_next;
    logic [1:0] win_sync_reg, win_sync_next;
    logic pd_prev_reg, pd_prev_next;
    logic [7:0] cnt_reg, cnt_next;
    logic lock_reg, lock_next;
    logic lost_reg, lost_next;
    logic tick, fall;

    always_comb begin
        pd_sync_next = {pd_sync_reg[0], i_pd_pin};
        win_sync_next = {win_sync_reg[0], i_win_pin};
        pd_prev_next = pd_sync_reg[1];
        tick = pd_sync_reg[1] & ~pd_prev_reg;
        cnt_next = cnt_reg;
        lock_next = lock_reg;
        if (i_off) begin
            cnt_next = 8'h00;
            lock_next = 1'b0;
        end else if (tick) begin
            if (!win_sync_reg[1]) begin
                cnt_next = 8'h00;
                lock_next = 1'b0;
            end else if (cnt_reg >= i_lock_cnt) begin
                lock_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + 8'h01;
            end
        end
        fall = lock_reg & ~lock_next;
        // Clear wins here: the flag is held low while the clear bit is set
        if (i_clear) begin
            lost_next = 1'b0;
        end else if (fall) begin
            lost_next = 1'b1;
        end else begin
            lost_next = lost_reg;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            pd_sync_reg <= 2'h0;
            win_sync_reg <= 2'h0;
            pd_prev_reg <= 1'b0;
            cnt_reg <= 8'h00;
            lock_reg <= 1'b0;
            lost_reg <= 1'b0;
        end else begin
            pd_sync_reg <= pd_sync_next;
            win_sync_reg <= win_sync_next;
            pd_prev_reg <= pd_prev_next;
            cnt_reg <= cnt_next;
            lock_reg <= lock_next;
            lost_reg <= lost_next;
        end
    end

    assign o_level = lock_reg;
    assign o_lost = lost_reg;
    assign o_event = fall & ~i_clear;

    a_lock_restart: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (tick && !win_sync_reg[1]) |=> (cnt_reg == 8'h00) && !lock_reg)
        else $error("lock count did not restart outside window");
endmodule // lsr_lock_det

module lsr_bank
    import lsr_pkg::*;
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    // Register port
    input wire logic [8:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    output logic o_irq,
    // Loop indications from pins
    input wire logic [1:0] i_pd_pin,
    input wire logic [1:0] i_win_pin,
    input wire lsr_misc_t i_misc,
    input wire logic [3:0] i_div_obs,
    input wire logic i_readback_bit,
    // Status pin two and power controls
    output logic o_pin2_out,
    output logic o_pin2_oe,
    output logic o_prescaler_off,
    output logic o_loop2_off
);
    lsr_pin_sel_t sel_reg, sel_next;
    logic [7:0] fix_a_reg, fix_a_next, fix_b_reg, fix_b_next;
    logic [7:0] opt_a_reg, opt_a_next, opt_b_reg, opt_b_next;
    logic [7:0] lcnt1_reg, lcnt1_next, lcnt2_reg, lcnt2_next;
    logic pre_reg, pre_next, off_reg, off_next;
    logic clr1_reg, clr1_next, clr2_reg, clr2_next;
    logic [1:0] stat_reg, stat_next, mask_reg, mask_next;
    logic [7:0] rdata_reg, rdata_next;
    logic irq_reg, irq_next;
    lsr_misc_t misc_s1_reg, misc_s2_reg;
    logic [3:0] obs_s1_reg, obs_s2_reg, obs_prev_reg, half_reg, half_next;
    logic pin_reg, pin_next, oe_reg, oe_next;
    logic lvl1, lvl2, lost1, lost2, ev1, ev2, src_val;

    lsr_lock_det u_det1 (
        .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_off(1'b0),
        .i_pd_pin(i_pd_pin[0]), .i_win_pin(i_win_pin[0]),
        .i_lock_cnt(lcnt1_reg), .i_clear(clr1_reg),
        .o_level(lvl1), .o_lost(lost1), .o_event(ev1)
    );
    lsr_lock_det u_det2 (
        .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_off(off_reg),
        .i_pd_pin(i_pd_pin[1]), .i_win_pin(i_win_pin[1]),
        .i_lock_cnt(lcnt2_reg), .i_clear(clr2_reg),
        .o_level(lvl2), .o_lost(lost2), .o_event(ev2)
    );

    // ******************************
    // Register writes and reads
    // ******************************
    always_comb begin
        sel_next = sel_reg;
        fix_a_next = fix_a_reg;
        fix_b_next = fix_b_reg;
        opt_a_next = opt_a_reg;
        opt_b_next = opt_b_reg;
        lcnt1_next = lcnt1_reg;
        lcnt2_next = lcnt2_reg;
        pre_next = pre_reg;
        off_next = off_reg;
        clr1_next = clr1_reg;
        clr2_next = clr2_reg;
        mask_next = mask_reg;
        stat_next = stat_reg;
        rdata_next = 8'h00;
        if (i_wr) begin
            case (i_addr)
                `LSR_ADDR_PIN2_SEL: sel_next = i_wdata;
                `LSR_ADDR_FIX_A: fix_a_next = i_wdata;
                `LSR_ADDR_FIX_B: fix_b_next = i_wdata;
                `LSR_ADDR_OPT_A: opt_a_next = i_wdata;
                `LSR_ADDR_OPT_B: opt_b_next = i_wdata;
                `LSR_ADDR_LCNT1: lcnt1_next = i_wdata;
                `LSR_ADDR_LCNT2: lcnt2_next = i_wdata;
                `LSR_ADDR_PWR: begin
                    pre_next = i_wdata[`LSR_BIT_PRE_OFF];
                    off_next = i_wdata[`LSR_BIT_LOOP_OFF];
                end
                `LSR_ADDR_LOCK1: clr1_next = i_wdata[`LSR_BIT_CLEAR];
                `LSR_ADDR_LOCK2: clr2_next = i_wdata[`LSR_BIT_CLEAR];
                `LSR_ADDR_IRQ_MASK: mask_next = i_wdata[1:0];
                `LSR_ADDR_IRQ_STAT: stat_next = stat_reg & ~i_wdata[1:0];
                default: ;
            endcase
        end
        // A new event wins over a write-one clear in the same cycle
        stat_next = stat_next | {ev2, ev1};
        irq_next = |(stat_next & mask_next);
        if (i_rd) begin
            case (i_addr)
                `LSR_ADDR_PIN2_SEL: rdata_next = sel_reg;
                `LSR_ADDR_FIX_A: rdata_next = fix_a_reg;
                `LSR_ADDR_FIX_B: rdata_next = fix_b_reg;
                `LSR_ADDR_OPT_A: rdata_next = opt_a_reg;
                `LSR_ADDR_OPT_B: rdata_next = opt_b_reg;
                `LSR_ADDR_LCNT1: rdata_next = lcnt1_reg;
                `LSR_ADDR_LCNT2: rdata_next = lcnt2_reg;
                `LSR_ADDR_PWR: rdata_next = {1'b0, pre_reg, off_reg, 5'h00};
                `LSR_ADDR_LOCK1: rdata_next = {5'h00, lost1, lvl1, clr1_reg};
                `LSR_ADDR_LOCK2: rdata_next = {5'h00, lost2, lvl2, clr2_reg};
                `LSR_ADDR_IRQ_STAT: rdata_next = {6'h00, stat_reg};
                `LSR_ADDR_IRQ_MASK: rdata_next = {6'h00, mask_reg};
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            sel_reg <= `LSR_RST_PIN2_SEL;
            fix_a_reg <= `LSR_RST_FIX_A;
            fix_b_reg <= `LSR_RST_FIX_B;
            opt_a_reg <= `LSR_RST_BYTE;
            opt_b_reg <= `LSR_RST_BYTE;
            lcnt1_reg <= `LSR_RST_LCNT;
            lcnt2_reg <= `LSR_RST_LCNT;
            pre_reg <= 1'b0;
            off_reg <= 1'b0;
            clr1_reg <= 1'b0;
            clr2_reg <= 1'b0;
            mask_reg <= 2'h0;
            stat_reg <= 2'h0;
            rdata_reg <= 8'h00;
            irq_reg <= 1'b0;
        end else begin
            sel_reg <= sel_next;
            fix_a_reg <= fix_a_next;
            fix_b_reg <= fix_b_next;
            opt_a_reg <= opt_a_next;
            opt_b_reg <= opt_b_next;
            lcnt1_reg <= lcnt1_next;
            lcnt2_reg <= lcnt2_next;
            pre_reg <= pre_next;
            off_reg <= off_next;
            clr1_reg <= clr1_next;
            clr2_reg <= clr2_next;
            mask_reg <= mask_next;
            stat_reg <= stat_next;
            rdata_reg <= rdata_next;
            irq_reg <= irq_next;
        end
    end

    // ******************************
    // Status pin two
    // ******************************
    always_comb begin
        half_next = half_reg ^ (obs_s2_reg & ~obs_prev_reg);
        case (lsr_src_t'(sel_reg.source))
            LSR_SRC_LOCK1: src_val = lvl1;
            LSR_SRC_LOCK2: src_val = lvl2;
            LSR_SRC_BOTH: src_val = lvl1 & lvl2;
            LSR_SRC_HOLD: src_val = misc_s2_reg.holdover;
            LSR_SRC_DACLK: src_val = misc_s2_reg.dac_locked;
            LSR_SRC_RDBK: src_val = i_readback_bit;
            LSR_SRC_RAIL: src_val = misc_s2_reg.dac_rail;
            LSR_SRC_DLOW: src_val = misc_s2_reg.dac_low;
            LSR_SRC_DHIGH: src_val = misc_s2_reg.dac_high;
            LSR_SRC_FB1: src_val = obs_s2_reg[0];
            LSR_SRC_FB1H: src_val = half_reg[0];
            LSR_SRC_FB2: src_val = obs_s2_reg[1];
            LSR_SRC_FB2H: src_val = half_reg[1];
            LSR_SRC_RF1: src_val = obs_s2_reg[2];
            LSR_SRC_RF1H: src_val = half_reg[2];
            LSR_SRC_RF2: src_val = obs_s2_reg[3];
            LSR_SRC_RF2H: src_val = half_reg[3];
            default: src_val = 1'b0;
        endcase
        // Reserved drive codes leave the pin undriven
        case (lsr_drv_t'(sel_reg.drive))
            LSR_DRV_PP: begin
                pin_next = src_val;
                oe_next = 1'b1;
            end
            LSR_DRV_PPINV: begin
                pin_next = ~src_val;
                oe_next = 1'b1;
            end
            LSR_DRV_OD: begin
                pin_next = 1'b0;
                oe_next = ~src_val;
            end
            default: begin
                pin_next = 1'b0;
                oe_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            misc_s1_reg <= '0;
            misc_s2_reg <= '0;
            obs_s1_reg <= 4'h0;
            obs_s2_reg <= 4'h0;
            obs_prev_reg <= 4'h0;
            half_reg <= 4'h0;
            pin_reg <= 1'b0;
            oe_reg <= 1'b0;
        end else begin
            misc_s1_reg <= i_misc;
            misc_s2_reg <= misc_s1_reg;
            obs_s1_reg <= i_div_obs;
            obs_s2_reg <= obs_s1_reg;
            obs_prev_reg <= obs_s2_reg;
            half_reg <= half_next;
            pin_reg <= pin_next;
            oe_reg <= oe_next;
        end
    end

    assign o_rdata = rdata_reg;
    assign o_irq = irq_reg;
    assign o_pin2_out = pin_reg;
    assign o_pin2_oe = oe_reg;
    assign o_prescaler_off = pre_reg;
    assign o_loop2_off = off_reg;

    // ******************************
    // Checks
    // ******************************
    a_lost1_set: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        ($fell(lvl1) && !$past(clr1_reg)) |-> lost1)
        else $error("first lost flag missed a lock fall");
    a_lost2_set: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        ($fell(lvl2) && !$past(clr2_reg)) |-> lost2)
        else $error("second lost flag missed a lock fall");
    a_clear1_hold: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        clr1_reg |=> !lost1)
        else $error("first lost flag set while clear held");
    a_clear2_hold: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        clr2_reg |=> !lost2)
        else $error("second lost flag set while clear held");
    a_level1_read: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_rd && i_addr == `LSR_ADDR_LOCK1) |=> o_rdata[1] == $past(lvl1))
        else $error("first level readback wrong");
    a_level2_read: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_rd && i_addr == `LSR_ADDR_LOCK2) |=> o_rdata[2:1] == $past({lost2, lvl2}))
        else $error("second status readback wrong");
    a_pin_both: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (sel_reg == 8'h1b) |=> o_pin2_out == $past(lvl1 & lvl2) && o_pin2_oe)
        else $error("combined lock not the AND");
    a_pin_low: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (sel_reg == 8'h03) |=> !o_pin2_out && o_pin2_oe)
        else $error("logic low selection drove high");
    a_drive_od: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (sel_reg.drive == 3'h6) |=> !o_pin2_out && o_pin2_oe == !$past(src_val))
        else $error("open drain drive wrong");
    a_power_bits: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_wr && i_addr == `LSR_ADDR_PWR) |=>
        {o_prescaler_off, o_loop2_off} == $past(i_wdata[6:5]))
        else $error("power bits not taken");
    a_loop_off: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        o_loop2_off |=> !lvl2)
        else $error("second loop locked while powered down");
    a_rsvd_zero: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_rd && (i_addr == `LSR_ADDR_LOCK1 || i_addr == `LSR_ADDR_PWR))
        |=> o_rdata[7] == 1'b0 && (o_rdata[4:3] == 2'h0))
        else $error("reserved bits read nonzero");
    c_lost1: cover property (@(posedge i_ref_clk) $rose(lost1));
    c_lock2: cover property (@(posedge i_ref_clk) $rose(lvl2));
    c_irq: cover property (@(posedge i_ref_clk) $rose(o_irq));
    c_od: cover property (@(posedge i_ref_clk) sel_reg.drive == 3'h6 && !o_pin2_oe);
endmodule // lsr_bank
`default_nettype wire

// ===== sim/tb_top.sv
// Self-checking testbench for the lock status register bank
`timescale 1ns/100ps
`default_nettype none
`include "lsr_regs.svh"

module tb_top
    import lsr_pkg::*;
;
    // ****************************************
    // Clock, reset and design inputs
    // ****************************************
    logic i_ref_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [8:0] i_addr = 9'h000;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [1:0] i_pd_pin = 2'h0;
    logic [1:0] i_win_pin = 2'h0;
    lsr_misc_t i_misc = 5'h15;
    logic [3:0] i_div_obs = 4'h5;
    logic i_readback_bit = 1'b1;
    logic [7:0] o_rdata;
    logic o_irq, o_pin2_out, o_pin2_oe, o_prescaler_off, o_loop2_off;
    int mismatches = 0;
    int tests_run = 0;
    logic lk1 = 1'b0;
    logic lk2 = 1'b0;
    // Expected halved divider outputs: each high bit has risen once since reset
    logic [3:0] hv = 4'h5;

    always #12.5 i_ref_clk = ~i_ref_clk;

    lsr_bank dut (
        .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .i_pd_pin(i_pd_pin),
        .i_win_pin(i_win_pin), .i_misc(i_misc), .i_div_obs(i_div_obs),
        .i_readback_bit(i_readback_bit), .o_pin2_out(o_pin2_out), .o_pin2_oe(o_pin2_oe),
        .o_prescaler_off(o_prescaler_off), .o_loop2_off(o_loop2_off)
    );

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [8:0] a, input logic [7:0] exp, input string what);
        @(posedge i_ref_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1;
        chk(o_rdata, exp, what);
    endtask

    // Phase-detector cycles, slow enough for the two-stage synchroniser
    task automatic pulse(input int n, input int k);
        repeat (k) begin
            @(posedge i_ref_clk);
            i_pd_pin[n] <= 1'b1;
            repeat (3) @(posedge i_ref_clk);
            i_pd_pin[n] <= 1'b0;
            repeat (3) @(posedge i_ref_clk);
        end
        repeat (6) @(posedge i_ref_clk);
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset_and_store();
        rd_chk(`LSR_ADDR_PIN2_SEL, 8'h16, "pin2 select reset");
        rd_chk(`LSR_ADDR_FIX_A, 8'h0a, "fixed a reset");
        rd_chk(`LSR_ADDR_FIX_B, 8'h00, "fixed b reset");
        rd_chk(`LSR_ADDR_PWR, 8'h00, "power reset");
        rd_chk(`LSR_ADDR_LOCK1, 8'h00, "lock1 reset");
        rd_chk(`LSR_ADDR_LOCK2, 8'h00, "lock2 reset");
        rd_chk(`LSR_ADDR_LCNT1, 8'h10, "lock count reset");
        wr(`LSR_ADDR_FIX_A, 8'haa);
        wr(`LSR_ADDR_FIX_B, 8'h02);
        wr(`LSR_ADDR_OPT_A, 8'h15);
        wr(`LSR_ADDR_OPT_B, 8'h33);
        wr(9'h1a0, 8'hff);
        rd_chk(`LSR_ADDR_FIX_A, 8'haa, "fixed a store");
        rd_chk(`LSR_ADDR_FIX_B, 8'h02, "fixed b store");
        rd_chk(`LSR_ADDR_OPT_A, 8'h15, "optimise a store");
        rd_chk(`LSR_ADDR_OPT_B, 8'h33, "optimise b store");
        rd_chk(9'h1a0, 8'h00, "unmapped read");
        $display("Test reset and store done");
    endtask

    // One loop: count, level, lost flag, clear hold, interrupt
    task automatic t_loop(input int n);
        logic [8:0] la;
        logic [7:0] bit_n;
        la = `LSR_ADDR_LOCK1 + 9'(n);
        bit_n = 8'h01 << n;
        wr(`LSR_ADDR_LCNT1 + 9'(n), 8'h02);
        i_win_pin[n] <= 1'b1;
        pulse(n, 2);
        rd_chk(la, 8'h00, "not locked before count");
        pulse(n, 1);
        rd_chk(la, 8'h02, "locked level");
        i_win_pin[n] <= 1'b0;
        pulse(n, 1);
        rd_chk(la, 8'h04, "lost flag on fall");
        rd_chk(`LSR_ADDR_IRQ_STAT, bit_n, "event status");
        chk({7'h00, o_irq}, 8'h00, "masked irq low");
        wr(`LSR_ADDR_IRQ_MASK, bit_n);
        repeat (2) @(posedge i_ref_clk);
        #1 chk({7'h00, o_irq}, 8'h01, "unmasked irq high");
        wr(`LSR_ADDR_IRQ_STAT, bit_n);
        repeat (2) @(posedge i_ref_clk);
        #1 chk({7'h00, o_irq}, 8'h00, "irq after clear");
        rd_chk(`LSR_ADDR_IRQ_STAT, 8'h00, "status after clear");
        i_win_pin[n] <= 1'b1;
        pulse(n, 2);
        rd_chk(la, 8'h04, "count restarted after window miss");
        pulse(n, 1);
        wr(la, 8'h01);
        rd_chk(la, 8'h03, "clear holds flag low");
        i_win_pin[n] <= 1'b0;
        pulse(n, 1);
        rd_chk(la, 8'h01, "fall while clear held");
        wr(la, 8'h00);
        rd_chk(la, 8'h00, "no set when cleared while low");
        $display("Test loop %0d done", n);
    endtask

    function automatic logic src_val(input logic [4:0] s);
        case (s)
            5'h01: return lk1;
            5'h02: return lk2;
            5'h03: return lk1 & lk2;
            5'h04: return i_misc.holdover;
            5'h05: return i_misc.dac_locked;
            5'h07: return i_readback_bit;
            5'h08: return i_misc.dac_rail;
            5'h09: return i_misc.dac_low;
            5'h0a: return i_misc.dac_high;
            5'h0b: return i_div_obs[0];
            5'h0c: return hv[0];
            5'h0d: return i_div_obs[1];
            5'h0e: return hv[1];
            5'h0f: return i_div_obs[2];
            5'h10: return hv[2];
            5'h11: return i_div_obs[3];
            5'h12: return hv[3];
            default: return 1'b0;
        endcase
    endfunction

    task automatic t_pin_table();
        logic [4:0] srcs [20] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07,
                                  5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f,
                                  5'h10, 5'h11, 5'h12, 5'h13};
        logic [2:0] drvs [4] = '{3'h3, 3'h4, 3'h6, 3'h5};
        logic v;
        logic [1:0] e;
        foreach (srcs[i]) begin
            foreach (drvs[j]) begin
                wr(`LSR_ADDR_PIN2_SEL, {srcs[i], drvs[j]});
                repeat (2) @(posedge i_ref_clk);
                #1;
                v = src_val(srcs[i]);
                e = (drvs[j] == 3'h3) ? {v, 1'b1} : (drvs[j] == 3'h4) ? {~v, 1'b1} :
                    (drvs[j] == 3'h6) ? {1'b0, ~v} : 2'b00;
                chk({6'h00, o_pin2_out, o_pin2_oe}, {6'h00, e}, "pin2 out and enable");
            end
        end
    endtask

    task automatic t_pin_and_power();
        wr(`LSR_ADDR_LCNT2, 8'h02);
        i_win_pin <= 2'b11;
        pulse(0, 3);
        lk1 = 1'b1;
        t_pin_table();
        pulse(1, 3);
        lk2 = 1'b1;
        // A second rise on the high divider bits toggles their halves back to low
        i_div_obs <= 4'h0;
        repeat (4) @(posedge i_ref_clk);
        i_div_obs <= 4'h5;
        repeat (4) @(posedge i_ref_clk);
        hv = 4'h0;
        t_pin_table();
        wr(`LSR_ADDR_PIN2_SEL, 8'h16);
        rd_chk(`LSR_ADDR_LOCK2, 8'h02, "second level with source two");
        wr(`LSR_ADDR_PWR, 8'hff);
        rd_chk(`LSR_ADDR_PWR, 8'h60, "power reserved bits");
        chk({6'h00, o_prescaler_off, o_loop2_off}, 8'h03, "power outputs on");
        repeat (4) @(posedge i_ref_clk);
        rd_chk(`LSR_ADDR_LOCK2, 8'h04, "loop off drops second lock");
        wr(`LSR_ADDR_PWR, 8'h20);
        #1 chk({6'h00, o_prescaler_off, o_loop2_off}, 8'h01, "prescaler back on");
        wr(`LSR_ADDR_PWR, 8'h00);
        #1 chk({6'h00, o_prescaler_off, o_loop2_off}, 8'h00, "power outputs off");
        wr(`LSR_ADDR_LOCK1, 8'hfe);
        rd_chk(`LSR_ADDR_LOCK1, 8'h02, "lock reserved bits");
        $display("Test pin and power done");
    endtask

    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial begin
        repeat (10) @(posedge i_ref_clk);
        i_sys_rst <= 1'b0;
        t_reset_and_store();
        t_loop(0);
        t_loop(1);
        t_pin_and_power();
        report_and_stop();
    end

    // The tests need about 1000 cycles; twenty times that is a hang
    initial begin
        repeat (20000) @(posedge i_ref_clk);
        mismatches++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        report_and_stop();
    end
endmodule // tb_top
`default_nettype wire
